// ==== verilog/kwu_pkg.sv ====
// Package with constants for the key wakeup standby release block
package kwu_pkg;
  localparam int          KWU_ADDR_W          = 16;
  localparam int          KWU_DATA_W          = 8;
  localparam int          KWU_PINS            = 4;
  localparam int          KWU_SYNC_DEPTH      = 2;
  // Register offsets
  localparam logic [15:0] KWU_KEY_WAKE_EN_ADR = 16'h0031;
  localparam logic [15:0] KWU_STATUS_ADR      = 16'h0032;
  localparam logic [15:0] KWU_MODE_ADR        = 16'h0033;
  // Field positions of the key wake enable register
  localparam int          KWU_EN_LSB          = 4;
  localparam int          KWU_EN_MSB          = 7;
  // Reset values
  localparam logic [3:0]  KWU_EN_RST          = 4'h0;
  localparam logic        KWU_RELM_RST        = 1'b0;
  // Warm-up time in ns and the derived cycle count
  localparam int          KWU_CLK_PERIOD_NS   = 25;
  localparam int          KWU_WARMUP_NS       = 1000;
  localparam int          KWU_WARMUP_CYC      = (KWU_WARMUP_NS + KWU_CLK_PERIOD_NS - 1) / KWU_CLK_PERIOD_NS;
  localparam int          KWU_WARM_W          = 8;
  typedef enum logic [1:0] {KWU_RUN, KWU_STANDBY, KWU_WARMUP} kwu_state_t;
endpackage : kwu_pkg

// ==== verilog/kwu_wake_comb.sv ====
// Clockless wakeup request combiner for the key pins and release pin
`timescale 1ns/1ps
module kwu_wake_comb
  import kwu_pkg::*;
(
  input  wire logic [3:0] key_pin_in,
  input  wire logic [3:0] key_en_in,
  input  wire logic       rel_pin_in,
  input  wire logic       relm_in,
  input  wire logic       rel_pin_prev_in,
  output logic            level_req_out,
  output logic            wake_req_out
);
  // Pure gates, so the request exists while the system clock is stopped
  always_comb
  begin
    level_req_out = rel_pin_in | (|(key_en_in & ~key_pin_in));
    if (relm_in)
      wake_req_out = level_req_out;
    else
      wake_req_out = rel_pin_in & ~rel_pin_prev_in;
  end
endmodule : kwu_wake_comb

// ==== verilog/kwu_key_wakeup.sv ====
// Key-on wakeup standby release top level
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module kwu_key_wakeup
(
  // Clock and reset
  input  wire logic                        SYS_CLK_IN,
  input  wire logic                        RST_IN,
  // Register port
  input  wire logic [kwu_pkg::KWU_ADDR_W-1:0] ADDR_IN,
  input  wire logic [kwu_pkg::KWU_DATA_W-1:0] WDATA_IN,
  input  wire logic                        WR_IN,
  input  wire logic                        RD_IN,
  output logic [kwu_pkg::KWU_DATA_W-1:0]   RDATA_OUT,
  // Pins: key_wake_pin_5..2 as bits 3..0, and dedicated release pin
  input  wire logic [3:0]                  KEY_WAKE_PIN_IN,
  input  wire logic                        REL_PIN_IN,
  // Core side
  input  wire logic                        STANDBY_ENTRY_IN,
  output logic [3:0]                       KEY_PORT_DATA_OUT,
  output logic                             STANDBY_OUT,
  output logic                             OSC_STOP_OUT,
  output logic                             WAKE_REQ_OUT,
  output logic                             WARMUP_DONE_OUT
);
  import kwu_pkg::*;

  // Run, standby and warm-up are the three sequencer states. Software
  // programs the key enables and the release mode over the register port,
  // and the core pulses the entry input in place of the standby instruction.

  // Register bus state
  logic [3:0]            key_en_r;
  logic [3:0]            key_en_nxt;
  logic                  relm_r;
  logic                  relm_nxt;
  logic                  rel_prev_r;
  logic                  rel_prev_nxt;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;
  logic [3:0]            port_r;
  logic [3:0]            port_nxt;
  // Sequencer state
  kwu_state_t            state_r;
  kwu_state_t            state_nxt;
  logic [KWU_WARM_W-1:0] warm_r;
  logic [KWU_WARM_W-1:0] warm_nxt;
  logic                  done_r;
  logic                  done_nxt;
  // Clockless request terms from the combiner
  logic                  level_req;
  logic                  wake_req;
  // Decodes shared by several processes
  logic                  wr_en_hit;
  logic                  wr_mode_hit;
  logic                  in_standby;

  // Full address compare; no mirrored addresses
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  // State decode for the standby, oscillator-stop and wake outputs
  function automatic logic is_standby(input kwu_state_t s);
    is_standby = (s == KWU_STANDBY);
  endfunction : is_standby

  // Warm-up count loaded on every way into warm-up
  function automatic logic [KWU_WARM_W-1:0] warm_load();
    warm_load = KWU_WARM_W'(KWU_WARMUP_CYC);
  endfunction : warm_load

  // Write decodes; bits 3..0 of an enable write have no storage
  assign wr_en_hit   = WR_IN & hit(ADDR_IN, KWU_KEY_WAKE_EN_ADR);
  assign wr_mode_hit = WR_IN & hit(ADDR_IN, KWU_MODE_ADR);
  assign in_standby  = is_standby(state_r);

  // Request combiner kept free of the clock, so in level mode a key press can end standby
  // with the oscillator stopped. The edge-mode term still reads the pin
  // history flop, which only moves while the clock runs: in edge mode the
  // release pin must rise after standby has been entered.
  kwu_wake_comb u_comb (
    .key_pin_in      (KEY_WAKE_PIN_IN),
    .key_en_in       (key_en_r),
    .rel_pin_in      (REL_PIN_IN),
    .relm_in         (relm_r),
    .rel_pin_prev_in (rel_prev_r),
    .level_req_out   (level_req),
    .wake_req_out    (wake_req)
  );

  // Register writes and reads; enable register is write-only
  // Release mode select sits in bit 0 of its own register; reset picks edge mode
  always_comb
  begin
    key_en_nxt   = key_en_r;
    relm_nxt     = relm_r;
    rel_prev_nxt = REL_PIN_IN;                                          // Edge-mode pin history
    // Plain port copy of the pins, one cycle late
    port_nxt     = KEY_WAKE_PIN_IN;
    // Read data stand for one cycle only, zero otherwise
    rdata_nxt    = 8'h00;
    if (wr_en_hit)
      key_en_nxt = WDATA_IN[KWU_EN_MSB:KWU_EN_LSB];
    if (wr_mode_hit)
      relm_nxt = WDATA_IN[0];
    if (RD_IN)
    begin
      // Enable register reads as zero since it is write-only
      if (hit(ADDR_IN, KWU_STATUS_ADR))
        rdata_nxt = {KEY_WAKE_PIN_IN, 1'b0, done_r, state_r};
      else if (hit(ADDR_IN, KWU_MODE_ADR))
        rdata_nxt = {7'h00, relm_r};
      else
        rdata_nxt = 8'h00;
    end
  end

  // Standby sequencer: run, standby, warm-up
  // The count is loaded on the way into warm-up and runs down to one, so
  // warm-up lasts exactly the warm-up count; done marks the return to run.
  always_comb
  begin
    state_nxt = state_r;
    warm_nxt  = warm_r;
    done_nxt  = 1'b0;                                                   // Done is a one-cycle pulse
    case (state_r)
      KWU_RUN:
        // Entry is only taken in run; pulses in other states are ignored
        if (STANDBY_ENTRY_IN)
        begin
          // A present release condition skips standby entirely
          if (level_req)
          begin
            state_nxt = KWU_WARMUP;
            warm_nxt  = warm_load();
          end
          else
            state_nxt = KWU_STANDBY;
        end
      KWU_STANDBY:
        // Level mode wakes on levels, edge mode on the release pin rising
        if (wake_req)
        begin
          state_nxt = KWU_WARMUP;
          warm_nxt  = warm_load();
        end
      KWU_WARMUP:
        // Stopping at one avoids an extra cycle spent at zero
        if (warm_r <= KWU_WARM_W'(1))
        begin
          state_nxt = KWU_RUN;
          warm_nxt  = '0;
          done_nxt  = 1'b1;
        end
        else
          warm_nxt = warm_r - KWU_WARM_W'(1);
      default:
        // Unused encoding falls back to run
        state_nxt = KWU_RUN;
    endcase
  end

  // Register bus flops
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      key_en_r   <= KWU_EN_RST;
      relm_r     <= KWU_RELM_RST;
      rel_prev_r <= 1'b0;
      rdata_r    <= 8'h00;
      port_r     <= 4'h0;
    end
    else
    begin
      key_en_r   <= key_en_nxt;
      relm_r     <= relm_nxt;
      rel_prev_r <= rel_prev_nxt;
      rdata_r    <= rdata_nxt;
      port_r     <= port_nxt;
    end
  end

  // Sequencer flops; a reset in standby returns to run with no done pulse
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_r <= KWU_RUN;
      warm_r  <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      warm_r  <= warm_nxt;
      done_r  <= done_nxt;
    end
  end

  // Outputs; oscillator-stop only while truly in standby
  // Both come from the state flop, so pin noise cannot glitch them
  assign RDATA_OUT         = rdata_r;
  assign KEY_PORT_DATA_OUT = port_r;
  assign STANDBY_OUT       = in_standby;
  assign OSC_STOP_OUT      = in_standby;
  assign WAKE_REQ_OUT      = wake_req & in_standby;
  assign WARMUP_DONE_OUT   = done_r;
endmodule : kwu_key_wakeup

// ==== tb/kwu_keys.sv ====
// Model of the keys and release switch outside the device
`timescale 1ns/1ps
module kwu_keys
(
  input  wire logic [3:0] press_in,
  input  wire logic       rel_in,
  output logic      [3:0] key_out,
  output logic            rel_out
);
  // Idle keys pulled up; a press grounds the pin
  // Pins always driven as digital inputs, never left analog or floating
  assign key_out = ~press_in;
  // Switch stays low unless asked to release
  assign rel_out = rel_in;
endmodule : kwu_keys

// ==== tb/kwu_key_wakeup_sva.sv ====
// Port checker for the key wakeup block
`timescale 1ns/1ps
module kwu_chk
  import kwu_pkg::*;
(
  input wire logic        SYS_CLK_IN, RST_IN, WR_IN, RD_IN, REL_PIN_IN, STANDBY_ENTRY_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0]  WDATA_IN, RDATA_OUT,
  input wire logic [3:0]  KEY_WAKE_PIN_IN, KEY_PORT_DATA_OUT,
  input wire logic        STANDBY_OUT, OSC_STOP_OUT, WAKE_REQ_OUT, WARMUP_DONE_OUT
);
  // Single domain, so one clock and reset
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  wo_read_a: assert property (RD_IN && ADDR_IN == KWU_KEY_WAKE_EN_ADR |=> RDATA_OUT == 8'h00)
    else $error("enable readable");
  osc_stop_a: assert property (OSC_STOP_OUT == STANDBY_OUT) else $error("osc stop");
  wake_gate_a: assert property (WAKE_REQ_OUT |-> STANDBY_OUT) else $error("wake outside");
  wake_exit_a: assert property (WAKE_REQ_OUT |=> !STANDBY_OUT) else $error("no exit");
  warm_len_a: assert property ($fell(STANDBY_OUT) |-> (!WARMUP_DONE_OUT)[*8] ##33 WARMUP_DONE_OUT)
    else $error("warm-up length");
  entry_imm_a: assert property (STANDBY_ENTRY_IN && REL_PIN_IN |=> !STANDBY_OUT) else $error("entered");
  rel_rise_a: assert property (STANDBY_OUT && $rose(REL_PIN_IN) |-> WAKE_REQ_OUT)
    else $error("release ignored");
  port_echo_a: assert property (!$past(RST_IN) |-> KEY_PORT_DATA_OUT == $past(KEY_WAKE_PIN_IN))
    else $error("port data");
endmodule : kwu_chk
bind kwu_key_wakeup kwu_chk u_chk (.*);

// ==== tb/kwu_key_wakeup_test.sv ====
// Self-checking bench for the key wakeup block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %0h expected %0h", $time, (a), (b)); end end
module kwu_key_wakeup_test;
  import kwu_pkg::*;
  logic        clk = 0, RST_IN = 1, WR_IN = 0, RD_IN = 0, STANDBY_ENTRY_IN = 0, rel = 0, mode = 0, sb = 0;
  logic [15:0] ADDR_IN = 0;
  logic [7:0]  WDATA_IN = 0, RDATA_OUT;
  logic [3:0]  KEY_WAKE_PIN_IN, KEY_PORT_DATA_OUT, press = 0, en = 0;
  logic        REL_PIN_IN, STANDBY_OUT, OSC_STOP_OUT, WAKE_REQ_OUT, WARMUP_DONE_OUT;
  int          n_errors = 0, comparisons = 0;
  integer      seed = 32'h4dcc_89ac;
  kwu_key_wakeup DUT (.SYS_CLK_IN(clk), .*);
  kwu_keys u_keys (.press_in(press), .rel_in(rel), .key_out(KEY_WAKE_PIN_IN), .rel_out(REL_PIN_IN));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Bus cycles; the model follows every write
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= w;
    RD_IN <= !w;
    if (w && a == KWU_KEY_WAKE_EN_ADR) en = d[7:4];
    if (w && a == KWU_MODE_ADR) mode = d[0];
    @(posedge clk);
    WR_IN <= 0;
    RD_IN <= 0;
    #1 if (!w) `CHK(RDATA_OUT, d)
  endtask : bus
  // Change pins; predict the wake request and warm-up end
  task automatic key(input logic [3:0] m, input logic r);
    logic w;
    w = sb & (mode ? (r | |(en & m)) : (r & !rel));
    @(posedge clk);
    press <= m;
    rel <= r;
    #1 `CHK(WAKE_REQ_OUT, w)
    sb = sb & !w;
    @(posedge clk);
    #1 `CHK(KEY_PORT_DATA_OUT, ~m)
    `CHK(STANDBY_OUT, sb)
    `CHK(OSC_STOP_OUT, sb)
    repeat (w ? 40 : 0) @(posedge clk);
    #1 if (w) `CHK(WARMUP_DONE_OUT, 1'b1)
  endtask : key
  // Entry goes straight to warm-up if a release source is active
  task automatic enter;
    logic imm;
    imm = rel | |(en & press);
    @(posedge clk);
    STANDBY_ENTRY_IN <= 1;
    @(posedge clk);
    STANDBY_ENTRY_IN <= 0;
    #1 `CHK(STANDBY_OUT, !imm)
    sb = !imm;
    repeat (imm ? 40 : 0) @(posedge clk);
    #1 if (imm) `CHK(WARMUP_DONE_OUT, 1'b1)
  endtask : enter
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    RST_IN <= 0;
    bus(0, KWU_KEY_WAKE_EN_ADR, 8'h00);
    bus(0, 16'h0040, 8'h00);
    bus(1, KWU_MODE_ADR, 8'h01);
    key(4'h1, 0);
    enter();
    key(4'h0, 1);
    key(4'h0, 0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1, KWU_KEY_WAKE_EN_ADR, {4'h1 << i, 4'($random(seed))});
      enter();
      bus(0, KWU_STATUS_ADR, 8'hF1);
      key(4'h1 << ((i + 1) % 4), 0);
      key(4'h1 << i, 0);
      key(4'h0, 0);
    end
    key(4'h8, 0);
    bus(0, KWU_STATUS_ADR, 8'h70);
    enter();
    key(4'h0, 1);
    enter();
    key(4'h0, 0);
    bus(1, KWU_MODE_ADR, 8'h00);
    bus(1, KWU_KEY_WAKE_EN_ADR, 8'h00);
    enter();
    key(4'h0, 1);
    end_of_test();
  end
  // Watchdog well past the expected run
  initial
  begin
    #50000;
    n_errors++;
    end_of_test();
  end
endmodule : kwu_key_wakeup_test
